//--- include/pcs_defines.vh
`ifndef PCS_DEFINES_VH
`define PCS_DEFINES_VH
// Interface modes per socket
`define PCS_MODE_W       2
`define PCS_MODE_MEM     2'h0
`define PCS_MODE_IO      2'h1
`define PCS_MODE_ATA     2'h2
// Bus widths
`define PCS_ADDR_W       26
`define PCS_DATA_W       16
// Cycle kinds from the host side
`define PCS_KIND_W       3
`define PCS_KIND_MEM_RD  3'h0
`define PCS_KIND_MEM_WR  3'h1
`define PCS_KIND_IO_RD   3'h2
`define PCS_KIND_IO_WR   3'h3
`define PCS_KIND_DMA_RD  3'h4
`define PCS_KIND_DMA_WR  3'h5
// Reset values
`define PCS_ADDR_RST     26'h0000000
`define PCS_DATA_RST     16'h0000
`endif

//--- hdl/pcs_socket.v
`default_nettype none
// One socket's select, address, strobe and data path
`include "pcs_defines.vh"
module pcs_socket
(
  input  wire                      clk,
  input  wire                      rst_n,
  input  wire [`PCS_MODE_W-1:0]    mode,
  input  wire                      dma_capable,
  input  wire                      cyc_active,
  input  wire [`PCS_KIND_W-1:0]    cyc_kind,
  input  wire                      cyc_attr,
  input  wire [`PCS_ADDR_W-1:0]    cyc_addr,
  input  wire [`PCS_DATA_W-1:0]    cyc_wdata,
  input  wire                      term_count,
  output reg                       space_sel_n,
  output reg  [`PCS_ADDR_W-1:0]    card_addr,
  output reg                       card_read_n,
  output reg                       card_write_n,
  output reg                       io_read_strobe_n,
  output reg                       io_write_strobe_n,
  output reg  [`PCS_DATA_W-1:0]    data_out,
  output reg                       data_oe,
  input  wire [`PCS_DATA_W-1:0]    data_in,
  output reg  [`PCS_DATA_W-1:0]    rdata
);
  reg  next_sel_n;
  reg  next_rd_n;
  reg  next_wr_n;
  reg  next_io_read_strobe_n_n;
  reg  next_io_write_strobe_n_n;
  reg  next_oe;
  wire is_dma;

  assign is_dma = cyc_active && dma_capable &&
                  (cyc_kind == `PCS_KIND_DMA_RD || cyc_kind == `PCS_KIND_DMA_WR);

  always @*
  begin
    next_sel_n  = 1'b1;
    next_rd_n   = 1'b1;
    next_wr_n   = 1'b1;
    next_io_read_strobe_n_n = 1'b1;
    next_io_write_strobe_n_n = 1'b1;
    next_oe     = 1'b0;
    case (mode)
      `PCS_MODE_MEM:
        next_sel_n = ~cyc_attr;
      `PCS_MODE_IO:
        next_sel_n = is_dma;
      `PCS_MODE_ATA:
        next_sel_n = 1'b1;
      default:
        next_sel_n = 1'b1;
    endcase
    if (cyc_active)
    begin
      case (cyc_kind)
        `PCS_KIND_MEM_RD:
          next_rd_n = 1'b0;
        `PCS_KIND_MEM_WR:
        begin
          next_wr_n = 1'b0;
          next_oe   = 1'b1;
        end
        `PCS_KIND_IO_RD:
          next_io_read_strobe_n_n = 1'b0;
        `PCS_KIND_IO_WR:
        begin
          next_io_write_strobe_n_n = 1'b0;
          next_oe     = 1'b1;
        end
        `PCS_KIND_DMA_WR:
        begin
          // Card supplies data; TC rides on the read strobe
          next_io_read_strobe_n_n = 1'b0;
          next_rd_n   = ~term_count;
          next_wr_n   = 1'b1;
        end
        `PCS_KIND_DMA_RD:
        begin
          next_io_write_strobe_n_n = 1'b0;
          next_oe     = 1'b1;
          next_wr_n   = ~term_count;
          next_rd_n   = 1'b1;
        end
        default:
          next_rd_n = 1'b1;
      endcase
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      space_sel_n       <= 1'b1;
      card_addr         <= `PCS_ADDR_RST;
      card_read_n       <= 1'b1;
      card_write_n      <= 1'b1;
      io_read_strobe_n  <= 1'b1;
      io_write_strobe_n <= 1'b1;
      data_out          <= `PCS_DATA_RST;
      data_oe           <= 1'b0;
      rdata             <= `PCS_DATA_RST;
    end
    else
    begin
      space_sel_n       <= next_sel_n;
      card_read_n       <= next_rd_n;
      card_write_n      <= next_wr_n;
      io_read_strobe_n  <= next_io_read_strobe_n_n;
      io_write_strobe_n <= next_io_write_strobe_n_n;
      data_oe           <= next_oe;
      if (cyc_active)
      begin
        card_addr <= cyc_addr;
        data_out  <= cyc_wdata;
      end
      // Sampled while the read strobe is already out, so card data had a cycle to settle
      if (!card_read_n || !io_read_strobe_n)
        rdata <= data_in;
    end
  end
endmodule // pcs_socket
`default_nettype wire

//--- hdl/pcs_strobe_select.v
`default_nettype none
// Notes on behaviour
// - Memory mode: space select picks attribute (low) or common (high) memory.
// - I/O mode, non-DMA: space select held low.
// - Dual socket, DMA to DMA-capable card: space select high in I/O-mode DMA cycles.
// - ATA mode: space select always high.
// - Each socket drives a 26-bit address to the card.
// - 16-bit data: driven on writes, sampled on reads.
// - Non-DMA memory read: card read strobe low.
// - DMA write: card read strobe low only while terminal count high.
// - Two sockets, fully separate signal sets including address buses.
// - Non-DMA memory write: write strobe low; held high in DMA writes.
// - DMA read: card write strobe low only while terminal count high.
`include "pcs_defines.vh"
module pcs_strobe_select
(
  input  wire                      clk,
  input  wire                      rst_n,
  input  wire                      dma_mode,
  input  wire                      vpp_valid_tc,
  input  wire [`PCS_MODE_W-1:0]    a_mode,
  input  wire                      a_dma_capable,
  input  wire                      a_cyc_active,
  input  wire [`PCS_KIND_W-1:0]    a_cyc_kind,
  input  wire                      a_cyc_attr,
  input  wire [`PCS_ADDR_W-1:0]    a_cyc_addr,
  input  wire [`PCS_DATA_W-1:0]    a_cyc_wdata,
  output wire                      a_space_sel_n,
  output wire [`PCS_ADDR_W-1:0]    a_card_addr,
  output wire                      a_card_read_n,
  output wire                      a_card_write_n,
  output wire                      a_io_read_strobe_n,
  output wire                      a_io_write_strobe_n,
  output wire [`PCS_DATA_W-1:0]    a_data_out,
  output wire                      a_data_oe,
  input  wire [`PCS_DATA_W-1:0]    a_data_in,
  output wire [`PCS_DATA_W-1:0]    a_rdata,
  input  wire [`PCS_MODE_W-1:0]    b_mode,
  input  wire                      b_dma_capable,
  input  wire                      b_cyc_active,
  input  wire [`PCS_KIND_W-1:0]    b_cyc_kind,
  input  wire                      b_cyc_attr,
  input  wire [`PCS_ADDR_W-1:0]    b_cyc_addr,
  input  wire [`PCS_DATA_W-1:0]    b_cyc_wdata,
  output wire                      b_space_sel_n,
  output wire [`PCS_ADDR_W-1:0]    b_card_addr,
  output wire                      b_card_read_n,
  output wire                      b_card_write_n,
  output wire                      b_io_read_strobe_n,
  output wire                      b_io_write_strobe_n,
  output wire [`PCS_DATA_W-1:0]    b_data_out,
  output wire                      b_data_oe,
  input  wire [`PCS_DATA_W-1:0]    b_data_in,
  output wire [`PCS_DATA_W-1:0]    b_rdata
);
  reg  tc_meta;
  reg  tc_sync;
  reg  dma_meta;
  reg  dma_sync;
  wire term_count;

  // Pin inputs pass two flops before use
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tc_meta  <= 1'b0;
      tc_sync  <= 1'b0;
      dma_meta <= 1'b0;
      dma_sync <= 1'b0;
    end
    else
    begin
      tc_meta  <= vpp_valid_tc;
      tc_sync  <= tc_meta;
      dma_meta <= dma_mode;
      dma_sync <= dma_meta;
    end
  end

  // Outside DMA mode the pin is supply status, so no terminal count
  assign term_count = dma_sync & tc_sync;

  // Separate instance per socket; only clk, rst_n, term_count and dma_sync are shared
  pcs_socket u_sock_a
  (
    .clk               (clk),
    .rst_n             (rst_n),
    .mode              (a_mode),
    .dma_capable       (a_dma_capable & dma_sync),
    .cyc_active        (a_cyc_active),
    .cyc_kind          (a_cyc_kind),
    .cyc_attr          (a_cyc_attr),
    .cyc_addr          (a_cyc_addr),
    .cyc_wdata         (a_cyc_wdata),
    .term_count        (term_count),
    .space_sel_n       (a_space_sel_n),
    .card_addr         (a_card_addr),
    .card_read_n       (a_card_read_n),
    .card_write_n      (a_card_write_n),
    .io_read_strobe_n  (a_io_read_strobe_n),
    .io_write_strobe_n (a_io_write_strobe_n),
    .data_out          (a_data_out),
    .data_oe           (a_data_oe),
    .data_in           (a_data_in),
    .rdata             (a_rdata)
  );

  pcs_socket u_sock_b
  (
    .clk               (clk),
    .rst_n             (rst_n),
    .mode              (b_mode),
    .dma_capable       (b_dma_capable & dma_sync),
    .cyc_active        (b_cyc_active),
    .cyc_kind          (b_cyc_kind),
    .cyc_attr          (b_cyc_attr),
    .cyc_addr          (b_cyc_addr),
    .cyc_wdata         (b_cyc_wdata),
    .term_count        (term_count),
    .space_sel_n       (b_space_sel_n),
    .card_addr         (b_card_addr),
    .card_read_n       (b_card_read_n),
    .card_write_n      (b_card_write_n),
    .io_read_strobe_n  (b_io_read_strobe_n),
    .io_write_strobe_n (b_io_write_strobe_n),
    .data_out          (b_data_out),
    .data_oe           (b_data_oe),
    .data_in           (b_data_in),
    .rdata             (b_rdata)
  );
endmodule // pcs_strobe_select
`default_nettype wire

//--- testbench/pcs_card_model.sv
`default_nettype none
module pcs_card_model
(
  input  wire logic        clk,
  input  wire logic        card_read_n,
  input  wire logic [25:0] card_addr,
  output logic      [15:0] data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last = 16'h0000;
  // Released bus flips, so a stale sample never matches
  assign data = card_read_n ? ~last : card_addr[15:0] ^ 16'hA5C3;
  always @(posedge clk)
    if (!card_read_n)
      last <= data;
endmodule // pcs_card_model
`default_nettype wire

//--- testbench/pcs_strobe_select_properties.sv
`default_nettype none
module pcs_strobe_select_properties
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        dma_mode,
  input wire logic        vpp_valid_tc,
  input wire logic [1:0]  a_mode,
  input wire logic        a_dma_capable,
  input wire logic        a_cyc_active,
  input wire logic [2:0]  a_cyc_kind,
  input wire logic        a_cyc_attr,
  input wire logic [25:0] a_cyc_addr,
  input wire logic        a_space_sel_n,
  input wire logic [25:0] a_card_addr,
  input wire logic        a_card_read_n,
  input wire logic        a_card_write_n,
  input wire logic [15:0] a_data_in,
  input wire logic [15:0] a_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence dma_on;
    (dma_mode && a_dma_capable)[*4];
  endsequence
  sequence tc_steady;
    (dma_mode && $stable(vpp_valid_tc))[*4];
  endsequence
  a_mem_select: assert property (a_mode == 2'h0 |=> a_space_sel_n == !$past(a_cyc_attr))
    else $error("select in memory mode");
  a_io_select: assert property (
    a_mode == 2'h1 && a_cyc_active && a_cyc_kind < 3'h4 |=> !a_space_sel_n)
    else $error("select in io mode");
  a_dma_select: assert property (
    dma_on ##0 (a_mode == 2'h1 && a_cyc_active && a_cyc_kind[2]) |=> a_space_sel_n)
    else $error("select in dma");
  a_ata_select: assert property (a_mode == 2'h2 |=> a_space_sel_n)
    else $error("select in ata mode");
  a_read_strobe: assert property (
    a_cyc_active && a_cyc_kind == 3'h0 |=> !a_card_read_n && a_card_addr == $past(a_cyc_addr))
    else $error("memory read");
  a_write_strobe: assert property (a_cyc_active && a_cyc_kind == 3'h1 |=> !a_card_write_n)
    else $error("memory write");
  a_rdata_take: assert property (!a_card_read_n |=> a_rdata == $past(a_data_in))
    else $error("read data");
  a_tc_dma_wr: assert property (
    tc_steady ##0 (a_cyc_active && a_cyc_kind == 3'h5)
    |=> a_card_read_n == !$past(vpp_valid_tc) && a_card_write_n)
    else $error("dma write strobes");
  a_tc_dma_rd: assert property (
    tc_steady ##0 (a_cyc_active && a_cyc_kind == 3'h4)
    |=> a_card_write_n == !$past(vpp_valid_tc) && a_card_read_n)
    else $error("dma read strobes");
endmodule // pcs_strobe_select_properties
bind pcs_strobe_select pcs_strobe_select_properties u_props (.*);
`default_nettype wire

//--- testbench/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, dma_mode = 0, vpp_valid_tc = 0, a_dma_capable = 0, a_cyc_active = 0;
  logic a_cyc_attr = 0, b_dma_capable = 0, b_cyc_active = 0, b_cyc_attr = 0;
  logic [1:0] a_mode = 0, b_mode = 0;
  logic [2:0] a_cyc_kind = 0, b_cyc_kind = 0;
  logic [25:0] a_cyc_addr = 0, b_cyc_addr = 0, a_card_addr, b_card_addr;
  logic [15:0] a_cyc_wdata = 0, b_cyc_wdata = 0, b_data_in = 0, a_data_in, a_data_out;
  logic [15:0] b_data_out, a_rdata, b_rdata;
  logic a_space_sel_n, a_card_read_n, a_card_write_n, a_io_read_strobe_n, a_io_write_strobe_n;
  logic a_data_oe, b_space_sel_n, b_card_read_n, b_card_write_n, b_io_read_strobe_n;
  logic b_io_write_strobe_n, b_data_oe;
  int miscompares = 0, total_checks = 0;
  always #5 clk = ~clk;
  pcs_strobe_select dut (.*);
  pcs_card_model card (.clk, .card_read_n(a_card_read_n), .card_addr(a_card_addr),
                       .data(a_data_in));
  task automatic chk(input string what, input logic [25:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic req(input logic [1:0] m, input logic [2:0] k, input logic at, input logic [25:0] ad);
    @(posedge clk);
    a_mode <= m;
    a_cyc_active <= 1'h1;
    a_cyc_kind <= k;
    a_cyc_attr <= at;
    a_cyc_addr <= ad;
    a_cyc_wdata <= ~ad[15:0];
    @(posedge clk);
    #1;
  endtask
  task automatic idle;
    @(posedge clk);
    a_cyc_active <= 1'h0;
    @(posedge clk);
    #1;
  endtask
  task automatic t_mem;
    for (int i = 0; i < 2; i++)
    begin
      req(2'h0, 3'h0, i[0], i ? 26'h3FFFFFF : 26'h0000001);
      chk("select", a_space_sel_n, !i[0]);
      chk("read_n", a_card_read_n, 1'h0);
      chk("addr", a_card_addr, i ? 26'h3FFFFFF : 26'h0000001);
      idle;
      chk("rdata", a_rdata, (i ? 16'hFFFF : 16'h0001) ^ 16'hA5C3);
    end
    req(2'h0, 3'h1, 1'h0, 26'h2AAAAAA);
    chk("write_n", a_card_write_n, 1'h0);
    chk("data_oe", a_data_oe, 1'h1);
    chk("data_out", a_data_out, 16'h5555);
    idle;
    chk("write_n off", a_card_write_n, 1'h1);
  endtask
  task automatic t_io_ata;
    for (int k = 2; k < 4; k++)
    begin
      req(2'h1, k[2:0], 1'h1, 26'h0000300);
      chk("io select", a_space_sel_n, 1'h0);
      chk("io read", a_io_read_strobe_n, k != 2);
      chk("io write", a_io_write_strobe_n, k != 3);
      idle;
    end
    req(2'h2, 3'h0, 1'h0, 26'h0000010);
    chk("ata select", a_space_sel_n, 1'h1);
    idle;
  endtask
  task automatic t_dma;
    for (int tc = 0; tc < 2; tc++)
    begin
      @(posedge clk);
      dma_mode <= 1'h1;
      a_dma_capable <= 1'h1;
      vpp_valid_tc <= tc[0];
      repeat (3) @(posedge clk);
      req(2'h1, 3'h5, 1'h0, 26'h0000040);
      chk("dma select", a_space_sel_n, 1'h1);
      chk("dma oe", a_card_read_n, !tc[0]);
      chk("dma we", a_card_write_n, 1'h1);
      idle;
      req(2'h1, 3'h4, 1'h0, 26'h0000040);
      chk("dma we tc", a_card_write_n, !tc[0]);
      chk("dma oe off", a_card_read_n, 1'h1);
      chk("dma data_oe", a_data_oe, 1'h1);
      idle;
    end
  endtask
  task automatic t_b;
    @(posedge clk);
    b_cyc_active <= 1'h1;
    b_cyc_addr <= 26'h1555555;
    b_data_in <= 16'h1234;
    @(posedge clk);
    #1;
    chk("b addr", b_card_addr, 26'h1555555);
    chk("a addr", a_card_addr, 26'h0000040);
    chk("b read_n", b_card_read_n, 1'h0);
    chk("b select", b_space_sel_n, 1'h1);
    @(posedge clk);
    b_cyc_active <= 1'h0;
    @(posedge clk);
    #1;
    chk("b rdata", b_rdata, 16'h1234);
    chk("b read_n off", b_card_read_n, 1'h1);
    chk("b data_oe", b_data_oe, 1'h0);
  endtask
  task automatic results;
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #20us;
    miscompares++;
    results;
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    t_mem;
    t_io_ata;
    t_dma;
    t_b;
    results;
  end
endmodule // tb
`default_nettype wire
